// file: hw/led_params.svh
// timing, reset and encoding constants for the port led indicator driver
`ifndef LED_PARAMS_SVH
`define LED_PARAMS_SVH

// ============================================================
// geometry
`define LED_PORTS            2
`define LED_PINS_PER_PORT    3
`define LED_PINS             6
`define LED_PIN_IDX_W        3
`define LED_DEF_W            4
`define LED_SPD_W            2

// ============================================================
// link speed encoding on i_speed
`define LED_SPD_TEN          2'h0
`define LED_SPD_FAST         2'h1
`define LED_SPD_GIG          2'h2

// ============================================================
// blink timing
`define LED_CLK_PERIOD_NS    10
`define LED_BLINK_HALF_NS    50_000_000
`define LED_BLINK_CYCLES     (`LED_BLINK_HALF_NS / `LED_CLK_PERIOD_NS)
`define LED_DIV_W            23
`define LED_STRETCH_W        2
`define LED_STRETCH_HALVES   2'h2

// ============================================================
// pin reset values
`define LED_OUT_RST          6'h00
`define LED_OEN_RST          6'h3f
`define LED_STRAP_RST        6'h00

`endif

// file: hw/led_pkg.sv
// types shared by the port led indicator driver
package led_pkg;

    // indicator definition held per pin
    typedef enum logic [3:0] {
        LED_FULL,
        LED_HALF,
        LED_LINK,
        LED_GIG_LINK,
        LED_FAST_LINK,
        LED_TEN_LINK,
        LED_ACT,
        LED_GIG_ACT,
        LED_FAST_ACT,
        LED_TEN_ACT,
        LED_TX_ACT,
        LED_RX_ACT,
        LED_LPI_ACT,
        LED_LOOP_ACT,
        LED_LINK_ACT,
        LED_OFF
    } led_def_e;

    // start-up sequence
    typedef enum logic [1:0] {
        ST_STRAP,
        ST_BLINK_ON,
        ST_BLINK_OFF,
        ST_RUN
    } led_state_e;

endpackage : led_pkg

// file: hw/led_act_stretch.sv
// activity stretcher: holds a short event for at least one blink half-period
`timescale 1ns/1ps
`default_nettype none
`include "led_params.svh"

module led_act_stretch (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // blink half-period tick and raw event
    input  wire logic i_tick,
    input  wire logic i_event,
    // stretched activity
    output var  logic o_busy
);

    logic [`LED_STRETCH_W-1:0] cnt_r;
    logic [`LED_STRETCH_W-1:0] cnt_nxt;

    // ============================================================
    // counter of remaining half-periods
    // two halves guarantee at least part of one lit phase whatever the event timing
    always_comb begin
        cnt_nxt = cnt_r;
        if (i_event) begin
            cnt_nxt = `LED_STRETCH_HALVES;
        end else if (i_tick && cnt_r != '0) begin
            cnt_nxt = cnt_r - `LED_STRETCH_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign o_busy = (cnt_r != '0);

    // ============================================================
    // checks
    AST_STRETCH_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_event |=> o_busy[*2])
        else $error("activity event not held for two cycles");

    COV_STRETCH_EXPIRE: cover property (@(posedge i_clk) disable iff (!i_rstn)
        $fell(o_busy));

endmodule : led_act_stretch

`default_nettype wire

// file: hw/port_led_indicator_driver.sv
// parallel led driver for the two copper ports, three pins each
`timescale 1ns/1ps
`default_nettype none
`include "led_params.svh"

module port_led_indicator_driver
    import led_pkg::*;
#(
    parameter logic [`LED_DIV_W-1:0] P_BLINK_CYCLES = `LED_DIV_W'(`LED_BLINK_CYCLES)
) (
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rstn,
    // per-port status, bit p belongs to port p (i_speed bits 2p+1:2p)
    input  wire logic [`LED_PORTS-1:0]     i_link_up,
    input  wire logic [2*`LED_PORTS-1:0]   i_speed,
    input  wire logic [`LED_PORTS-1:0]     i_full_duplex,
    input  wire logic [`LED_PORTS-1:0]     i_tx_act,
    input  wire logic [`LED_PORTS-1:0]     i_rx_act,
    input  wire logic [`LED_PORTS-1:0]     i_lpi,
    input  wire logic [`LED_PORTS-1:0]     i_loop,
    // definition write port
    input  wire logic                      i_cfg_we,
    input  wire logic [`LED_PIN_IDX_W-1:0] i_cfg_pin,
    input  wire logic [`LED_DEF_W-1:0]     i_cfg_def,
    // power-on blink controls
    input  wire logic                      i_power_on_blink_strap,
    input  wire logic                      i_power_on_blink_en,
    // led pins, index port*3 + pin
    input  wire logic [`LED_PINS-1:0]      i_led_in,
    output var  logic [`LED_PINS-1:0]      o_led_out,
    output var  logic [`LED_PINS-1:0]      o_led_oen,
    // status
    output var  logic [`LED_PINS-1:0]      o_led_polarity,
    output var  logic                      o_led_running
);

    // ============================================================
    // blink divider
    logic [`LED_DIV_W-1:0] div_r;
    logic [`LED_DIV_W-1:0] div_nxt;
    logic                  tick_r;
    logic                  tick_nxt;
    logic                  phase_r;
    logic                  phase_nxt;

    // one rate for every pin keeps paired leds in step
    always_comb begin
        tick_nxt  = 1'b0;
        div_nxt   = div_r + `LED_DIV_W'(1);
        phase_nxt = phase_r;
        if (div_r == P_BLINK_CYCLES - `LED_DIV_W'(1)) begin
            div_nxt  = '0;
            tick_nxt = 1'b1;
        end
        if (tick_r) begin
            phase_nxt = ~phase_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_r   <= '0;
            tick_r  <= 1'b0;
            phase_r <= 1'b0;
        end else begin
            div_r   <= div_nxt;
            tick_r  <= tick_nxt;
            phase_r <= phase_nxt;
        end
    end

    // ============================================================
    // activity stretchers, one per port and direction
    logic [`LED_PORTS-1:0] tx_busy;
    logic [`LED_PORTS-1:0] rx_busy;

    genvar gp;
    generate
        for (gp = 0; gp < `LED_PORTS; gp++) begin : g_port
            led_act_stretch u_tx (
                .i_clk   (i_clk),
                .i_rstn  (i_rstn),
                .i_tick  (tick_r),
                .i_event (i_tx_act[gp]),
                .o_busy  (tx_busy[gp])
            );
            led_act_stretch u_rx (
                .i_clk   (i_clk),
                .i_rstn  (i_rstn),
                .i_tick  (tick_r),
                .i_event (i_rx_act[gp]),
                .o_busy  (rx_busy[gp])
            );
        end
    endgenerate

    // ============================================================
    // definition table
    led_def_e sel_r   [`LED_PINS];
    led_def_e sel_nxt [`LED_PINS];

    always_comb begin
        for (int i = 0; i < `LED_PINS; i++) begin
            sel_nxt[i] = sel_r[i];
        end
        // out-of-range pin index is ignored
        if (i_cfg_we && i_cfg_pin < `LED_PIN_IDX_W'(`LED_PINS)) begin
            sel_nxt[i_cfg_pin] = led_def_e'(i_cfg_def);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int p = 0; p < `LED_PORTS; p++) begin
                sel_r[p*`LED_PINS_PER_PORT]     <= LED_LINK_ACT;
                sel_r[p*`LED_PINS_PER_PORT + 1] <= LED_GIG_LINK;
                sel_r[p*`LED_PINS_PER_PORT + 2] <= LED_FAST_LINK;
            end
        end else begin
            for (int i = 0; i < `LED_PINS; i++) begin
                sel_r[i] <= sel_nxt[i];
            end
        end
    end

    // ============================================================
    // indication per pin
    logic [`LED_PINS-1:0] lit_vec;

    always_comb begin
        logic [`LED_SPD_W-1:0] spd;
        logic                  lk;
        logic                  act_blink;
        int                    pin;
        spd       = `LED_SPD_TEN;
        lk        = 1'b0;
        act_blink = 1'b0;
        pin       = 0;
        lit_vec   = '0;
        for (int p = 0; p < `LED_PORTS; p++) begin
            spd       = i_speed[`LED_SPD_W*p +: `LED_SPD_W];
            lk        = i_link_up[p];
            act_blink = (tx_busy[p] | rx_busy[p]) & phase_r;
            for (int k = 0; k < `LED_PINS_PER_PORT; k++) begin
                pin = p*`LED_PINS_PER_PORT + k;
                case (sel_r[pin])
                    LED_FULL:      lit_vec[pin] = lk & i_full_duplex[p];
                    LED_HALF:      lit_vec[pin] = lk & ~i_full_duplex[p];
                    LED_LINK:      lit_vec[pin] = lk;
                    LED_GIG_LINK:  lit_vec[pin] = lk & (spd == `LED_SPD_GIG);
                    LED_FAST_LINK: lit_vec[pin] = lk & (spd == `LED_SPD_FAST);
                    LED_TEN_LINK:  lit_vec[pin] = lk & (spd == `LED_SPD_TEN);
                    LED_ACT:       lit_vec[pin] = act_blink;
                    LED_GIG_ACT:   lit_vec[pin] = lk & (spd == `LED_SPD_GIG) & act_blink;
                    LED_FAST_ACT:  lit_vec[pin] = lk & (spd == `LED_SPD_FAST) & act_blink;
                    LED_TEN_ACT:   lit_vec[pin] = lk & (spd == `LED_SPD_TEN) & act_blink;
                    LED_TX_ACT:    lit_vec[pin] = tx_busy[p] & phase_r;
                    LED_RX_ACT:    lit_vec[pin] = rx_busy[p] & phase_r;
                    LED_LPI_ACT:   lit_vec[pin] = i_lpi[p] & phase_r;
                    LED_LOOP_ACT:  lit_vec[pin] = i_loop[p] & phase_r;
                    // steady on while linked, dark flashes on traffic
                    LED_LINK_ACT:  lit_vec[pin] = lk & ~(act_blink);
                    default:       lit_vec[pin] = 1'b0;
                endcase
            end
        end
    end

    // ============================================================
    // start-up sequence and pin drive
    led_state_e           st_r;
    led_state_e           st_nxt;
    logic [`LED_PINS-1:0] strap_r;
    logic [`LED_PINS-1:0] strap_nxt;
    logic [`LED_PINS-1:0] out_r;
    logic [`LED_PINS-1:0] out_nxt;
    logic [`LED_PINS-1:0] oen_r;
    logic [`LED_PINS-1:0] oen_nxt;
    logic                 running_r;
    logic                 running_nxt;

    always_comb begin
        st_nxt    = st_r;
        strap_nxt = strap_r;
        oen_nxt   = '0;
        case (st_r)
            ST_STRAP: begin
                // pins still float as inputs on this edge, so the strap is valid
                strap_nxt = i_led_in;
                if (i_power_on_blink_strap && i_power_on_blink_en) begin
                    st_nxt = ST_BLINK_ON;
                end else begin
                    st_nxt = ST_RUN;
                end
            end
            ST_BLINK_ON: begin
                if (tick_r) begin
                    st_nxt = ST_BLINK_OFF;
                end
            end
            ST_BLINK_OFF: begin
                if (tick_r) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                st_nxt = ST_RUN;
            end
            default: begin
                st_nxt = ST_RUN;
            end
        endcase
        case (st_nxt)
            ST_BLINK_ON:  out_nxt = ~strap_nxt;
            ST_BLINK_OFF: out_nxt = strap_nxt;
            default:      out_nxt = lit_vec ^ strap_nxt;
        endcase
        running_nxt = (st_nxt == ST_RUN);
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r      <= ST_STRAP;
            strap_r   <= `LED_STRAP_RST;
            out_r     <= `LED_OUT_RST;
            oen_r     <= `LED_OEN_RST;
            running_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            strap_r   <= strap_nxt;
            out_r     <= out_nxt;
            oen_r     <= oen_nxt;
            running_r <= running_nxt;
        end
    end

    assign o_led_out      = out_r;
    assign o_led_oen      = oen_r;
    assign o_led_polarity = strap_r;
    assign o_led_running  = running_r;

    // ============================================================
    // checks
    AST_DEFAULT_DEFS: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_r == ST_STRAP) |-> (sel_r[0] == LED_LINK_ACT && sel_r[1] == LED_GIG_LINK
                                && sel_r[2] == LED_FAST_LINK && sel_r[3] == LED_LINK_ACT
                                && sel_r[4] == LED_GIG_LINK && sel_r[5] == LED_FAST_LINK))
        else $error("pin definitions not at defaults after reset");

    AST_DRIVE_AFTER_RESET: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_r != ST_STRAP) |-> (o_led_oen == '0 && o_led_polarity == strap_r))
        else $error("led pin not driving after reset release");

    // polarity must be what the released pin showed on the first edge out of reset
    AST_STRAP_CAPTURE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_r == ST_STRAP) |=> (o_led_polarity == $past(i_led_in)))
        else $error("strap not captured from pin levels");

    AST_POLARITY: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_r == ST_RUN && $past(st_r) == ST_RUN) |-> (o_led_out == ($past(lit_vec) ^ strap_r)))
        else $error("led output polarity does not follow strap");

    AST_LINK_PIN: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (sel_r[3] == LED_LINK) |-> (lit_vec[3] == i_link_up[1]))
        else $error("link pin does not follow link state");

    AST_DUPLEX_PIN: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (sel_r[0] == LED_HALF && i_link_up[0] && i_full_duplex[0]) |-> !lit_vec[0])
        else $error("half duplex pin lit at full duplex");

    AST_SPEED_LINK: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (sel_r[1] == LED_GIG_LINK)
        |-> (lit_vec[1] == (i_link_up[0] && i_speed[1:0] == `LED_SPD_GIG)))
        else $error("gigabit link pin wrong");

    AST_BICOLOR: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (sel_r[1] == LED_GIG_LINK && sel_r[2] == LED_FAST_LINK) |-> !(lit_vec[1] && lit_vec[2]))
        else $error("exclusive pins lit together");

    AST_LPI_PIN: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (sel_r[3] == LED_LPI_ACT && !i_lpi[1]) |-> !lit_vec[3])
        else $error("idle pin lit outside low power idle");

    AST_TX_ONLY: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (sel_r[3] == LED_TX_ACT && !tx_busy[1]) |-> !lit_vec[3])
        else $error("transmit pin lit without transmit activity");

    AST_POWER_BLINK: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_r == ST_BLINK_ON) |-> (o_led_out == ~strap_r))
        else $error("power-on blink not lighting all leds");

    COV_POWER_BLINK: cover property (@(posedge i_clk) disable iff (!i_rstn)
        (st_r == ST_BLINK_OFF) ##1 (st_r == ST_RUN));
    COV_MIXED_STRAP: cover property (@(posedge i_clk) disable iff (!i_rstn)
        (st_r == ST_RUN) && strap_r[0] && !strap_r[1]);
    COV_CFG_WRITE: cover property (@(posedge i_clk) disable iff (!i_rstn)
        (st_r == ST_RUN) && i_cfg_we);

endmodule : port_led_indicator_driver

`default_nettype wire

// file: tb/led_board.sv
// board model: strap resistors and leds hanging on the six led pins
`timescale 1ns/1ps
`default_nettype none

module led_board (
    // strap resistor per pin, 1 = pull-up
    input  wire logic [5:0] i_pull,
    // pin drive from the device
    input  wire logic [5:0] i_drive,
    input  wire logic [5:0] i_oen,
    // pin level and led state seen on the board
    output wire logic [5:0] o_level,
    output wire logic [5:0] o_lit
);
    // ============================================================
    // pin resolution
    // a released pin floats to its strap resistor, never to the last driven value
    assign o_level = (i_oen & i_pull) | (~i_oen & i_drive);
    // led sits against the strap rail, so it lights when the pin leaves that rail
    assign o_lit   = o_level ^ i_pull;
endmodule : led_board

`default_nettype wire

// file: tb/port_led_indicator_driver_bench.sv
// self-checking bench for the port led indicator driver
`timescale 1ns/1ps
`default_nettype none
`include "led_params.svh"

module port_led_indicator_driver_bench
    import led_pkg::*;
;
    // ============================================================
    // signals
    localparam int BLINK = 8;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [1:0] link_up = 2'h0, full_dup = 2'h0, tx_act = 2'h0, rx_act = 2'h0;
    logic [1:0] lpi = 2'h0, loop_det = 2'h0;
    logic [3:0] speed = 4'h0;
    logic       cfg_we = 1'b0, pob_strap = 1'b0, pob_en = 1'b0;
    logic [2:0] cfg_pin = 3'h0;
    logic [3:0] cfg_def = 4'h0;
    logic [5:0] pull = 6'h3f;
    logic [5:0] led_in, led_out, led_oen, led_pol, lit;
    logic       running;
    logic [3:0] defs [6];
    logic [31:0] seed_r = 32'h0000_005d;
    int         err_total = 0;
    int         samples_checked = 0;

    localparam logic [3:0] POOL [8] = '{LED_FULL, LED_HALF, LED_LINK, LED_GIG_LINK,
                                        LED_FAST_LINK, LED_TEN_LINK, LED_LINK_ACT, LED_OFF};
    // stimulus code: speed[5:4] tx rx lpi loop; a pass case then a must-stay-dark case, LED_LINK_ACT pass case only
    localparam logic [3:0] TDEF [17] = '{LED_ACT, LED_ACT, LED_GIG_ACT, LED_GIG_ACT,
        LED_FAST_ACT, LED_FAST_ACT, LED_TEN_ACT, LED_TEN_ACT, LED_TX_ACT, LED_TX_ACT,
        LED_RX_ACT, LED_RX_ACT, LED_LPI_ACT, LED_LPI_ACT, LED_LOOP_ACT, LED_LOOP_ACT,
        LED_LINK_ACT};
    localparam logic [5:0] TSTIM [17] = '{6'h28, 6'h20, 6'h24, 6'h14, 6'h18, 6'h08,
        6'h04, 6'h24, 6'h28, 6'h24, 6'h24, 6'h28, 6'h22, 6'h20, 6'h21, 6'h20, 6'h28};
    localparam logic TEXP [17] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
        1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    always #5 clk = ~clk;

    // ============================================================
    // design and board
    port_led_indicator_driver #(.P_BLINK_CYCLES(`LED_DIV_W'(BLINK))) DUT (
        .i_clk(clk), .i_rstn(rstn), .i_link_up(link_up), .i_speed(speed),
        .i_full_duplex(full_dup), .i_tx_act(tx_act), .i_rx_act(rx_act), .i_lpi(lpi),
        .i_loop(loop_det), .i_cfg_we(cfg_we), .i_cfg_pin(cfg_pin), .i_cfg_def(cfg_def),
        .i_power_on_blink_strap(pob_strap), .i_power_on_blink_en(pob_en),
        .i_led_in(led_in), .o_led_out(led_out), .o_led_oen(led_oen),
        .o_led_polarity(led_pol), .o_led_running(running));

    led_board board (.i_pull(pull), .i_drive(led_out), .i_oen(led_oen),
                     .o_level(led_in), .o_lit(lit));

    // ============================================================
    // helpers
    function automatic logic [31:0] xs_next();
        seed_r = seed_r ^ (seed_r << 13);
        seed_r = seed_r ^ (seed_r >> 17);
        seed_r = seed_r ^ (seed_r << 5);
        return seed_r;
    endfunction : xs_next

    // steady indication expected from the status currently applied
    function automatic logic lit_of(input logic [3:0] d, input int p);
        logic [1:0] s;
        s = speed[2*p +: 2];
        case (d)
            LED_FULL:      return link_up[p] & full_dup[p];
            LED_HALF:      return link_up[p] & ~full_dup[p];
            LED_LINK:      return link_up[p];
            LED_LINK_ACT:  return link_up[p];
            LED_GIG_LINK:  return link_up[p] & (s == `LED_SPD_GIG);
            LED_FAST_LINK: return link_up[p] & (s == `LED_SPD_FAST);
            LED_TEN_LINK:  return link_up[p] & (s == `LED_SPD_TEN);
            default:       return 1'b0;
        endcase
    endfunction : lit_of

    task automatic chk_vec(input string what, input logic [5:0] exp, input logic [5:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_vec

    task automatic chk_flag(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task automatic cfg_write(input logic [2:0] pin, input logic [3:0] def);
        @(posedge clk);
        cfg_we  <= 1'b1;
        cfg_pin <= pin;
        cfg_def <= def;
        @(posedge clk);
        cfg_we  <= 1'b0;
        if (pin < 3'h6)
            defs[pin] = def;
    endtask : cfg_write

    task automatic check_static();
        logic [5:0] exp;
        repeat (3) @(posedge clk);
        @(negedge clk);
        for (int i = 0; i < 6; i++)
            exp[i] = lit_of(defs[i], i / 3);
        chk_vec("pin_lit", exp, lit);
    endtask : check_static

    task automatic do_reset(input logic [5:0] straps, input logic blink);
        int on_cnt;
        on_cnt = 0;
        @(posedge clk);
        rstn <= 1'b0;
        pull <= straps;
        pob_strap <= blink;
        pob_en <= blink;
        {link_up, tx_act, rx_act, lpi, loop_det, speed} <= '0;
        for (int i = 0; i < 6; i++)
            defs[i] = (i % 3 == 0) ? LED_LINK_ACT : (i % 3 == 1) ? LED_GIG_LINK : LED_FAST_LINK;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk_vec("oen_in_reset", 6'h3f, led_oen);
        chk_flag("running_in_reset", 1'b0, running);
        @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < 8 * BLINK && running !== 1'b1; k++) begin
            @(negedge clk);
            on_cnt += (lit === 6'h3f) ? 1 : 0;
        end
        chk_flag("power_on_blink", blink, on_cnt > 0);
        chk_flag("running", 1'b1, running);
        chk_vec("polarity", straps, led_pol);
        chk_vec("oen_after_reset", 6'h00, led_oen);
        $display("test reset straps %h blink %b done", straps, blink);
    endtask : do_reset

    task automatic blink_case(input logic [3:0] def, input logic [5:0] stim, input logic exp);
        int cnt;
        cnt = 0;
        cfg_write(3'h3, def);
        @(posedge clk);
        link_up[1] <= 1'b1;
        speed[3:2] <= stim[5:4];
        {tx_act[1], rx_act[1], lpi[1], loop_det[1]} <= stim[3:0];
        // long enough for any stretched event of the previous case to die out
        repeat (4 * BLINK + 8) @(posedge clk);
        repeat (4 * BLINK) begin
            @(negedge clk);
            cnt += lit[3] ? 1 : 0;
        end
        chk_flag("blink_pin", exp, exp ? (cnt > 0 && cnt < 4 * BLINK) : (cnt > 0));
        $display("test blink def %0d done", def);
    endtask : blink_case

    // ============================================================
    // sequence
    initial begin
        logic [31:0] r;
        int cnt;
        do_reset(6'h3f, 1'b0);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            link_up <= 2'h3;
            speed <= {2{2'(s)}};
            check_static();
            chk_flag("bicolor", 1'b0, lit[1] & lit[2]);
        end
        $display("test defaults done");
        do_reset(6'h2d, 1'b1);
        for (int n = 0; n < 40; n++) begin
            r = xs_next();
            @(posedge clk);
            link_up <= r[1:0];
            speed <= r[5:2];
            full_dup <= r[7:6];
            cfg_write(r[10:8], POOL[r[13:11]]);
            check_static();
        end
        $display("test random definitions done");
        for (int i = 0; i < 17; i++)
            blink_case(TDEF[i], TSTIM[i], TEXP[i]);
        blink_case(LED_ACT, 6'h20, 1'b0);
        @(posedge clk);
        tx_act[1] <= 1'b1;
        @(posedge clk);
        tx_act[1] <= 1'b0;
        cnt = 0;
        repeat (4 * BLINK) begin
            @(negedge clk);
            cnt += lit[3] ? 1 : 0;
        end
        chk_flag("short_event", 1'b1, cnt > 0);
        $display("test short event done");
        close_out();
    end

    // ============================================================
    // watchdog, about ten times the expected run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule : port_led_indicator_driver_bench

`default_nettype wire
